// file: verilog/cpu_interrupt_sequencer.sv
// Interrupt entry, return and boundary arbitration between peripherals and the CPU core
`timescale 1ns/1ps
module cpu_interrupt_sequencer #(
  parameter int NUM_SRC = 13,
  parameter int IDX_W = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic instrDone,
  input wire logic swiExec,
  input wire logic rtiExec,
  input wire logic [NUM_SRC-1:0] irqReq,
  input wire logic [NUM_SRC-1:0] irqEnable,
  input wire logic [15:0] pcIn,
  input wire logic [15:0] spIn,
  input wire logic [7:0] accIn,
  input wire logic [7:0] idxLoIn,
  input wire logic [7:0] ccrIn,
  input wire logic [7:0] busRdData,
  output logic [15:0] busAddr_ff,
  output logic [7:0] busWrData_ff,
  output logic busWrite_ff,
  output logic busRead_ff,
  output logic busy_ff,
  output logic fetchGo_ff,
  output logic resumeStb_ff,
  output logic prefetchValid_ff,
  output logic [15:0] pcOut_ff,
  output logic [15:0] spOut_ff,
  output logic [7:0] accOut_ff,
  output logic [7:0] idxLoOut_ff,
  output logic [7:0] ccrOut_ff,
  output logic [7:0] opcodeOut_ff,
  output logic [7:0] operandOut_ff
);

  // ****************************************
  // State and working registers
  // ****************************************
  int_seq_pkg::seq_state_t state_ff, nxt_state;
  int_seq_pkg::rd_tag_t tag_ff, nxt_tag;
  logic [2:0] step_ff;
  logic [2:0] nxt_step;
  logic isRti_ff;
  logic [15:0] retPc_ff;
  logic [15:0] sp_ff;
  logic [15:0] vec_ff;
  logic [7:0] acc_ff;
  logic [7:0] idx_ff;
  logic [7:0] ccr_ff;
  logic [7:0] vecHi_ff;
  logic [7:0] opc_ff;

  // ****************************************
  // Arbitration
  // ****************************************
  logic [NUM_SRC-1:0] pending;
  logic anyPending;
  logic [IDX_W-1:0] winIdx;
  logic maskNow;
  logic hwTake;
  logic [15:0] hwVector;
  logic inIdle;
  logic inCheck;

  assign pending = irqReq & irqEnable;
  assign inIdle = (state_ff == int_seq_pkg::S_IDLE);
  assign inCheck = (state_ff == int_seq_pkg::S_CHECK);
  // In the return check the mask is the one just pulled, not the core's
  assign maskNow = inCheck ? ccr_ff[int_seq_pkg::CCR_I_BIT] : ccrIn[int_seq_pkg::CCR_I_BIT];
  assign hwTake = anyPending && !maskNow;
  assign hwVector = int_seq_pkg::HW_VECTOR_TOP - {11'h000, winIdx, 1'b0};

  irq_prio_enc #(
    .NUM_SRC(NUM_SRC),
    .IDX_W(IDX_W)
  ) u_prio (
    .req(pending),
    .any(anyPending),
    .idx(winIdx)
  );

  // Boundary decisions happen on the core's completion pulse, except the chained entry taken in the return check
  logic startSwi;
  logic startRti;
  logic startHw;
  logic chainHw;
  logic startEntry;
  assign startSwi = inIdle && instrDone && swiExec;
  assign startRti = inIdle && instrDone && !swiExec && rtiExec;
  assign startHw = inIdle && instrDone && !swiExec && !rtiExec && hwTake;
  assign chainHw = inCheck && hwTake;
  assign startEntry = startSwi || startHw || chainHw;

  // ****************************************
  // Bus step selection
  // ****************************************
  logic lastStep;
  logic [15:0] pushAddr;
  logic [15:0] pullAddr;
  logic [15:0] restoredPc;
  assign lastStep = (step_ff == int_seq_pkg::LAST_STEP);
  assign pushAddr = sp_ff - {13'h0000, step_ff};
  assign pullAddr = sp_ff + {13'h0000, step_ff} + 16'h0001;
  // Low byte arrives on the bus in the same cycle the opcode address is formed
  assign restoredPc = {retPc_ff[15:8], busRdData};

  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_tag = int_seq_pkg::T_NONE;
    case (state_ff)
      int_seq_pkg::S_IDLE: begin
        nxt_step = 3'h0;
        if (startEntry) begin
          nxt_state = int_seq_pkg::S_PUSH;
        end else if (startRti) begin
          nxt_state = int_seq_pkg::S_PULL;
          nxt_tag = int_seq_pkg::T_CCR;
        end
      end
      int_seq_pkg::S_PUSH: begin
        nxt_step = step_ff + 3'h1;
        if (lastStep) begin
          nxt_state = int_seq_pkg::S_VECH;
          nxt_tag = int_seq_pkg::T_VECH;
        end
      end
      int_seq_pkg::S_VECH: begin
        nxt_state = int_seq_pkg::S_VECL;
        nxt_tag = int_seq_pkg::T_VECL;
      end
      int_seq_pkg::S_VECL: begin
        nxt_state = int_seq_pkg::S_DONE;
      end
      int_seq_pkg::S_PULL: begin
        nxt_step = step_ff + 3'h1;
        if (lastStep) begin
          nxt_state = int_seq_pkg::S_OPC;
          nxt_tag = int_seq_pkg::T_OPC;
        end else begin
          nxt_tag = int_seq_pkg::rd_tag_t'(4'(step_ff) + 4'h2);
        end
      end
      int_seq_pkg::S_OPC: begin
        nxt_state = int_seq_pkg::S_OPR;
        nxt_tag = int_seq_pkg::T_OPR;
      end
      int_seq_pkg::S_OPR: begin
        nxt_state = int_seq_pkg::S_CHECK;
      end
      int_seq_pkg::S_CHECK: begin
        nxt_step = 3'h0;
        nxt_state = chainHw ? int_seq_pkg::S_PUSH : int_seq_pkg::S_DONE;
      end
      default: begin
        nxt_state = int_seq_pkg::S_IDLE;
      end
    endcase
  end

  // ****************************************
  // Sequencer registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= int_seq_pkg::S_IDLE;
      step_ff <= 3'h0;
      tag_ff <= int_seq_pkg::T_NONE;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      tag_ff <= nxt_tag;
    end
  end

  // Working copy of the frame, loaded from the core or from the stack
  always_ff @(posedge clk) begin
    if (!rstn) begin
      retPc_ff <= int_seq_pkg::RST_WORD;
      sp_ff <= int_seq_pkg::RST_WORD;
      vec_ff <= int_seq_pkg::RST_WORD;
      acc_ff <= int_seq_pkg::RST_BYTE;
      idx_ff <= int_seq_pkg::RST_BYTE;
      ccr_ff <= int_seq_pkg::RST_BYTE;
      vecHi_ff <= int_seq_pkg::RST_BYTE;
      opc_ff <= int_seq_pkg::RST_BYTE;
      isRti_ff <= 1'b0;
    end else begin
      if (startSwi || startHw || startRti) begin
        sp_ff <= spIn;
        acc_ff <= accIn;
        idx_ff <= idxLoIn;
        ccr_ff <= ccrIn;
        isRti_ff <= startRti;
      end
      if (startSwi) begin
        retPc_ff <= pcIn;
      end else if (startHw) begin
        retPc_ff <= pcIn - 16'h0001;
      end
      if (startSwi) begin
        vec_ff <= int_seq_pkg::SWI_VECTOR;
      end else if (startHw || chainHw) begin
        vec_ff <= hwVector;
      end
      if (chainHw) begin
        // The prefetched opcode is discarded; the resumed PC is stacked as is
        isRti_ff <= 1'b0;
      end
      if (state_ff == int_seq_pkg::S_PUSH && lastStep) begin
        sp_ff <= sp_ff - int_seq_pkg::STACK_FRAME;
      end
      if (state_ff == int_seq_pkg::S_PULL && lastStep) begin
        sp_ff <= sp_ff + int_seq_pkg::STACK_FRAME;
      end
      if (busRead_ff) begin
        case (tag_ff)
          int_seq_pkg::T_CCR: ccr_ff <= busRdData;
          int_seq_pkg::T_ACC: acc_ff <= busRdData;
          int_seq_pkg::T_IDX: idx_ff <= busRdData;
          int_seq_pkg::T_PCH: retPc_ff[15:8] <= busRdData;
          int_seq_pkg::T_PCL: retPc_ff[7:0] <= busRdData;
          int_seq_pkg::T_VECH: vecHi_ff <= busRdData;
          int_seq_pkg::T_VECL: vec_ff <= {vecHi_ff, busRdData};
          int_seq_pkg::T_OPC: opc_ff <= busRdData;
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // Bus outputs
  // ****************************************
  logic [15:0] nxt_addr;
  logic nxt_write;
  logic nxt_read;
  logic [15:0] pushNextAddr;
  assign pushNextAddr = startEntry ? (startSwi || startHw ? spIn : sp_ff) : pushAddr - 16'h0001;

  always_comb begin
    nxt_addr = busAddr_ff;
    nxt_write = 1'b0;
    nxt_read = 1'b0;
    if (nxt_state == int_seq_pkg::S_PUSH) begin
      nxt_addr = pushNextAddr;
      nxt_write = 1'b1;
    end else if (nxt_state == int_seq_pkg::S_VECH) begin
      nxt_addr = vec_ff;
      nxt_read = 1'b1;
    end else if (nxt_state == int_seq_pkg::S_VECL) begin
      nxt_addr = vec_ff + 16'h0001;
      nxt_read = 1'b1;
    end else if (nxt_state == int_seq_pkg::S_PULL) begin
      nxt_addr = startRti ? spIn + 16'h0001 : pullAddr + 16'h0001;
      nxt_read = 1'b1;
    end else if (nxt_state == int_seq_pkg::S_OPC) begin
      nxt_addr = restoredPc;
      nxt_read = 1'b1;
    end else if (nxt_state == int_seq_pkg::S_OPR) begin
      nxt_addr = retPc_ff + 16'h0001;
      nxt_read = 1'b1;
    end
  end

  // Push data follows the step that the address belongs to
  logic [7:0] nxt_wrData;
  logic [2:0] pushNextStep;
  assign pushNextStep = startEntry ? 3'h0 : step_ff + 3'h1;
  // Index high byte is deliberately absent from the frame
  assign nxt_wrData = (pushNextStep == 3'h0) ? retPc_ff[7:0] :
                      (pushNextStep == 3'h1) ? retPc_ff[15:8] :
                      (pushNextStep == 3'h2) ? idx_ff :
                      (pushNextStep == 3'h3) ? acc_ff : ccr_ff;

  // Entry data from the core is not yet in the working copy on the start cycle
  logic [7:0] entryFirst;
  assign entryFirst = startSwi ? pcIn[7:0] : pcIn[7:0] - 8'h01;
  logic [7:0] wrSel;
  assign wrSel = (startSwi || startHw) ? entryFirst :
                 (chainHw ? retPc_ff[7:0] : nxt_wrData);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      busAddr_ff <= int_seq_pkg::RST_WORD;
      busWrData_ff <= int_seq_pkg::RST_BYTE;
      busWrite_ff <= 1'b0;
      busRead_ff <= 1'b0;
    end else begin
      busAddr_ff <= nxt_addr;
      busWrData_ff <= nxt_write ? wrSel : int_seq_pkg::RST_BYTE;
      busWrite_ff <= nxt_write;
      busRead_ff <= nxt_read;
    end
  end

  // ****************************************
  // Hand-back to the core
  // ****************************************
  logic doneNow;
  logic [7:0] entryCcr;
  assign doneNow = (state_ff == int_seq_pkg::S_DONE);
  assign entryCcr = ccr_ff | (8'h01 << int_seq_pkg::CCR_I_BIT);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
      fetchGo_ff <= 1'b0;
      resumeStb_ff <= 1'b0;
      prefetchValid_ff <= 1'b0;
      pcOut_ff <= int_seq_pkg::RST_WORD;
      spOut_ff <= int_seq_pkg::RST_WORD;
      accOut_ff <= int_seq_pkg::RST_BYTE;
      idxLoOut_ff <= int_seq_pkg::RST_BYTE;
      ccrOut_ff <= int_seq_pkg::RST_BYTE;
      opcodeOut_ff <= int_seq_pkg::RST_BYTE;
      operandOut_ff <= int_seq_pkg::RST_BYTE;
    end else begin
      busy_ff <= (nxt_state != int_seq_pkg::S_IDLE);
      fetchGo_ff <= inIdle && instrDone && !swiExec && !rtiExec && !hwTake;
      resumeStb_ff <= doneNow;
      if (doneNow) begin
        prefetchValid_ff <= isRti_ff;
        pcOut_ff <= isRti_ff ? retPc_ff + 16'h0001 : vec_ff;
        spOut_ff <= sp_ff;
        accOut_ff <= acc_ff;
        idxLoOut_ff <= idx_ff;
        ccrOut_ff <= isRti_ff ? ccr_ff : entryCcr;
        opcodeOut_ff <= opc_ff;
      end
      if (busRead_ff && tag_ff == int_seq_pkg::T_OPR) begin
        operandOut_ff <= busRdData;
      end
    end
  end

endmodule : cpu_interrupt_sequencer

// file: verilog/int_seq_pkg.sv
// Shared constants, state encoding and bus tags of the interrupt sequencer
//
// Contract
// - Hardware requests never abort an instruction; service starts after it completes.
// - At each boundary take a request only if mask clear and source enabled.
// - Several unmasked requests pending: highest priority served first, others stay pending.
// - Request pending at return is served before the next interrupted instruction.
// - Return always prefetches the resumed opcode, even when a chained entry follows.
// - Entry never stacks the index high byte; only the other registers.
// - Software interrupt instruction always enters, whatever the global mask bit.
// - Software interrupt stacks current PC; hardware interrupt stacks PC minus one.
// - Return pulls flags, A, X low, PC high, PC low, then fetches opcode, operand.
package int_seq_pkg;

  // ****************************************
  // Condition codes and vectors
  // ****************************************
  localparam int CCR_I_BIT = 3;
  localparam logic [15:0] SWI_VECTOR = 16'hfffc;
  // Hardware source n takes the vector pair HW_VECTOR_TOP - 2*n
  localparam logic [15:0] HW_VECTOR_TOP = 16'hfffa;
  localparam logic [15:0] STACK_FRAME = 16'h0005;
  localparam logic [2:0] LAST_STEP = 3'h4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_PUSH = 4'h1,
    S_VECH = 4'h2,
    S_VECL = 4'h3,
    S_PULL = 4'h4,
    S_OPC = 4'h5,
    S_OPR = 4'h6,
    S_CHECK = 4'h7,
    S_DONE = 4'h8
  } seq_state_t;

  // ****************************************
  // Tags naming the byte a read returns
  // ****************************************
  typedef enum logic [3:0] {
    T_NONE = 4'h0,
    T_CCR = 4'h1,
    T_ACC = 4'h2,
    T_IDX = 4'h3,
    T_PCH = 4'h4,
    T_PCL = 4'h5,
    T_VECH = 4'h6,
    T_VECL = 4'h7,
    T_OPC = 4'h8,
    T_OPR = 4'h9
  } rd_tag_t;

endpackage : int_seq_pkg

// file: verilog/irq_prio_enc.sv
// Fixed priority encoder: lowest request index is highest priority
`timescale 1ns/1ps
module irq_prio_enc #(
  parameter int NUM_SRC = 13,
  parameter int IDX_W = 4
) (
  input wire logic [NUM_SRC-1:0] req,
  output logic any,
  output logic [IDX_W-1:0] idx
);

  always_comb begin
    any = 1'b0;
    idx = '0;
    // Walk from low priority upward so the highest one found wins
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = IDX_W'(i);
      end
    end
  end

endmodule : irq_prio_enc

// file: testbench/int_seq_mem.sv
// Behavioural core-side memory answering the sequencer's bus
`timescale 1ns/1ps
module int_seq_mem (
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdData
);
  logic [7:0] mem [0:65535];
  logic [7:0] lastRd_ff = 8'h00;
  // Idle bus shows the inverse of the last byte so a late sample cannot pass by chance
  assign rdData = rd ? mem[addr] : ~lastRd_ff;
  // Plain always: the bench also preloads this array directly
  always @(posedge clk) begin
    if (wr) mem[addr] <= wrData;
    if (rd) lastRd_ff <= mem[addr];
  end
endmodule : int_seq_mem

// file: testbench/cpu_interrupt_sequencer_asserts.sv
// Port checker for the interrupt sequencer
`timescale 1ns/1ps
module cpu_interrupt_sequencer_asserts #(
  parameter int NUM_SRC = 13
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic instrDone,
  input wire logic swiExec,
  input wire logic rtiExec,
  input wire logic [NUM_SRC-1:0] irqReq,
  input wire logic [NUM_SRC-1:0] irqEnable,
  input wire logic [15:0] pcIn,
  input wire logic [15:0] spIn,
  input wire logic [7:0] ccrIn,
  input wire logic [15:0] busAddr_ff,
  input wire logic [7:0] busWrData_ff,
  input wire logic busWrite_ff,
  input wire logic busRead_ff,
  input wire logic busy_ff,
  input wire logic fetchGo_ff,
  input wire logic resumeStb_ff,
  input wire logic prefetchValid_ff,
  input wire logic [7:0] ccrOut_ff
);
  logic [15:0] pcQ;
  logic [15:0] spQ;
  logic [15:0] pcDec;
  logic take;
  logic hwGo;
  assign take = instrDone && !busy_ff;
  assign hwGo = !ccrIn[3] && (|(irqReq & irqEnable));
  assign pcDec = pcQ - 16'h0001;
  always_ff @(posedge clk) begin
    pcQ <= pcIn;
    spQ <= spIn;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_idle_fetch: assert property (take && !swiExec && !rtiExec && !hwGo |=> fetchGo_ff)
    else $error("boundary without request did not fetch");
  chk_hw_take: assert property (take && !swiExec && !rtiExec && hwGo |=> busy_ff)
    else $error("enabled request not taken");
  chk_swi_vector: assert property (take && swiExec |=> busy_ff ##5
    (busRead_ff && busAddr_ff == int_seq_pkg::SWI_VECTOR)) else $error("software entry vector");
  chk_swi_pc: assert property (take && swiExec |=> busAddr_ff == spQ &&
    busWrData_ff == pcQ[7:0]) else $error("software entry stacked pc");
  chk_hw_pc: assert property (take && !swiExec && !rtiExec && hwGo |=>
    busWrData_ff == pcDec[7:0]) else $error("hardware entry stacked pc");
  chk_entry_seq: assert property ($rose(busy_ff) && busWrite_ff |-> busWrite_ff[*5]
    ##1 busRead_ff[*2] ##2 (resumeStb_ff && !busy_ff)) else $error("entry sequence");
  chk_stack_down: assert property (busWrite_ff && $past(busWrite_ff) |->
    busAddr_ff == $past(busAddr_ff) - 16'h0001) else $error("stack not descending");
  chk_pull_seq: assert property ($rose(busy_ff) && busRead_ff |->
    busAddr_ff == spQ + 16'h0001 ##0 busRead_ff[*7] ##1 !busRead_ff) else $error("return reads");
  chk_mask_set: assert property (resumeStb_ff && !prefetchValid_ff |-> ccrOut_ff[3])
    else $error("mask not set on entry");
  chk_busy_quiet: assert property (busy_ff |-> !fetchGo_ff && !resumeStb_ff)
    else $error("boundary answered while busy");
endmodule : cpu_interrupt_sequencer_asserts
bind cpu_interrupt_sequencer cpu_interrupt_sequencer_asserts #(.NUM_SRC(NUM_SRC)) chk_i (
  .clk(clk), .rstn(rstn), .instrDone(instrDone), .swiExec(swiExec), .rtiExec(rtiExec),
  .irqReq(irqReq), .irqEnable(irqEnable), .pcIn(pcIn), .spIn(spIn), .ccrIn(ccrIn),
  .busAddr_ff(busAddr_ff), .busWrData_ff(busWrData_ff), .busWrite_ff(busWrite_ff),
  .busRead_ff(busRead_ff), .busy_ff(busy_ff), .fetchGo_ff(fetchGo_ff),
  .resumeStb_ff(resumeStb_ff), .prefetchValid_ff(prefetchValid_ff), .ccrOut_ff(ccrOut_ff));

// file: testbench/testbench.sv
// Self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
module testbench;
  localparam int NS = 13;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic instrDone = 1'b0;
  logic swiExec = 1'b0;
  logic rtiExec = 1'b0;
  logic [NS-1:0] irqReq = '0;
  logic [NS-1:0] irqEnable = '0;
  logic [15:0] pcIn = 16'h0000, spIn = 16'h0000, busAddr_ff, pcOut_ff, spOut_ff;
  logic [7:0] accIn = 8'h00, idxLoIn = 8'h00, ccrIn = 8'h00, busRdData, busWrData_ff;
  logic [7:0] accOut_ff, idxLoOut_ff, ccrOut_ff, opcodeOut_ff, operandOut_ff;
  logic busWrite_ff, busRead_ff, busy_ff, fetchGo_ff, resumeStb_ff, prefetchValid_ff;
  int nMismatch = 0;
  int samplesChecked = 0;
  int cyc = 0;

  cpu_interrupt_sequencer #(.NUM_SRC(NS)) cpu_interrupt_sequencer_i (
    .clk(clk), .rstn(rstn), .instrDone(instrDone), .swiExec(swiExec), .rtiExec(rtiExec),
    .irqReq(irqReq), .irqEnable(irqEnable), .pcIn(pcIn), .spIn(spIn), .accIn(accIn),
    .idxLoIn(idxLoIn), .ccrIn(ccrIn), .busRdData(busRdData), .busAddr_ff(busAddr_ff),
    .busWrData_ff(busWrData_ff), .busWrite_ff(busWrite_ff), .busRead_ff(busRead_ff),
    .busy_ff(busy_ff), .fetchGo_ff(fetchGo_ff), .resumeStb_ff(resumeStb_ff),
    .prefetchValid_ff(prefetchValid_ff), .pcOut_ff(pcOut_ff), .spOut_ff(spOut_ff),
    .accOut_ff(accOut_ff), .idxLoOut_ff(idxLoOut_ff), .ccrOut_ff(ccrOut_ff),
    .opcodeOut_ff(opcodeOut_ff), .operandOut_ff(operandOut_ff));
  int_seq_mem int_seq_mem_i (.clk(clk), .addr(busAddr_ff), .wrData(busWrData_ff),
    .wr(busWrite_ff), .rd(busRead_ff), .rdData(busRdData));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task print_verdict;
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      nMismatch++;
      print_verdict();
    end
  end

  function automatic logic [7:0] rd(input logic [15:0] ad);
    return int_seq_mem_i.mem[ad];
  endfunction : rd

  // ****************************************
  // One boundary: model, drive, compare
  // ****************************************
  task automatic boundary(input int kind, input int pulled, input logic [7:0] c,
      input logic [NS-1:0] rq, input logic [NS-1:0] en);
    int src, lat, n, enter;
    logic [15:0] pc, sp, base, spc, vec, epc;
    logic [7:0] ea, ex, ec, below;
    logic [7:0] stk [$];
    pc = 16'h8000 | 16'($urandom % 16'h4000);
    sp = 16'h0100 + 16'($urandom % 16'h0100);
    ea = 8'($urandom);
    ex = 8'($urandom);
    ec = c;
    if (pulled >= 0) int_seq_mem_i.mem[sp + 16'h0001] = 8'(pulled);
    src = -1;
    for (int i = NS - 1; i >= 0; i--) begin
      if (rq[i] && en[i]) src = i;
    end
    base = sp;
    spc = kind == 0 ? pc - 16'h0001 : pc;
    vec = 16'hfffc;
    lat = 1;
    if (kind == 2) begin
      ec = rd(sp + 16'h0001);
      ea = rd(sp + 16'h0002);
      ex = rd(sp + 16'h0003);
      spc = {rd(sp + 16'h0004), rd(sp + 16'h0005)};
      base = sp + 16'h0005;
      lat = 10;
    end
    enter = kind == 1 || (!ec[3] && src >= 0);
    epc = spc + 16'h0001;
    if (enter) begin
      if (kind != 1) vec = 16'hfffa - 16'(2 * src);
      lat = kind == 2 ? 17 : 9;
      epc = {rd(vec), rd(vec + 16'h0001)};
      stk = '{spc[7:0], spc[15:8], ex, ea, ec};
      below = rd(base - 16'h0005);
    end
    @(negedge clk);
    instrDone = 1'b1;
    swiExec = kind == 1;
    rtiExec = kind == 2;
    pcIn = pc;
    spIn = sp;
    accIn = kind == 2 ? 8'h00 : ea;
    idxLoIn = kind == 2 ? 8'h00 : ex;
    ccrIn = c;
    irqReq = rq;
    irqEnable = en;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      // A boundary offered mid-sequence must be ignored
      instrDone = n == 3;
      swiExec = 1'b0;
      rtiExec = 1'b0;
    end while (fetchGo_ff !== 1'b1 && resumeStb_ff !== 1'b1 && n < 40);
    check(16'(n), 16'(lat));
    check(16'(fetchGo_ff), 16'(lat == 1));
    if (lat > 1) begin
      check(pcOut_ff, epc);
      check(spOut_ff, enter ? base - 16'h0005 : base);
      check(16'(ccrOut_ff), 16'(enter ? ec | 8'h08 : ec));
      check({accOut_ff, idxLoOut_ff}, {ea, ex});
      check(16'(prefetchValid_ff), 16'(!enter));
      for (int k = 0; k < 5; k++) begin
        if (enter) check(16'(rd(base - 16'(k))), 16'(stk[k]));
      end
      // The core keeps its own index high byte; nothing lands below the frame
      if (enter) check(16'(rd(base - 16'h0005)), 16'(below));
      if (!enter) check({opcodeOut_ff, operandOut_ff}, {rd(spc), rd(spc + 16'h0001)});
    end
  endtask : boundary

  initial begin
    void'($urandom(2));
    for (int i = 0; i < 65536; i++) begin
      int_seq_mem_i.mem[i] = 8'($urandom);
    end
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    boundary(0, -1, 8'h00, '0, '1);
    boundary(0, -1, 8'h08, 13'h1fff, '1);
    boundary(0, -1, 8'h00, 13'h0020, 13'h1fdf);
    $display("test 1 done");
    boundary(1, -1, 8'h08, 13'h0001, '1);
    for (int s = 0; s < NS; s++) begin
      boundary(0, -1, 8'($urandom) & 8'hf7, NS'($urandom) << s | NS'(1) << s,
        NS'($urandom) | NS'(1) << s);
    end
    $display("test 2 done");
    boundary(2, 8'h08, 8'h00, 13'h0004, '1);
    boundary(2, 8'h00, 8'h08, 13'h0004, '1);
    boundary(2, 8'h00, 8'h00, '0, '1);
    $display("test 3 done");
    // Reset in the middle of an entry must abandon it cleanly
    @(negedge clk);
    instrDone = 1'b1;
    swiExec = 1'b1;
    @(negedge clk);
    instrDone = 1'b0;
    swiExec = 1'b0;
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    check({busy_ff, busWrite_ff, pcOut_ff[13:0]}, 16'h0000);
    rstn = 1'b1;
    boundary(0, -1, 8'h00, 13'h0002, '1);
    $display("test reset done");
    for (int r = 0; r < 40; r++) begin
      boundary(int'($urandom % 3), -1, 8'($urandom), NS'($urandom), NS'($urandom));
    end
    $display("test 4 done");
    print_verdict();
  end
endmodule : testbench
